// ==== fwr_pkg.sv ====
// shared constants and types of the wrap, reset, sleep and id command logic
package fwr_pkg;
  // opcodes handled here
  localparam logic [7:0] OP_WRAP    = 8'h77;
  localparam logic [7:0] OP_QREAD   = 8'heb;
  localparam logic [7:0] OP_RST_EN  = 8'h66;
  localparam logic [7:0] OP_RST     = 8'h99;
  localparam logic [7:0] OP_SLEEP   = 8'hb9;
  localparam logic [7:0] OP_RELEASE = 8'hab;
  localparam logic [7:0] OP_MFR_DEV = 8'h90;
  // arbitrary identity values
  localparam logic [7:0] MFR_ID_DEF = 8'h5a;
  localparam logic [7:0] DEV_ID_DEF = 8'h13;
  // last edge index of each phase, rising for input phases and falling for output bytes
  localparam logic [4:0] LAST_OPC   = 5'h07;
  localparam logic [4:0] LAST_ADR1  = 5'h17; // 24 single bits
  localparam logic [4:0] LAST_ADR4  = 5'h05; // 24 bits, four per clock
  localparam logic [4:0] LAST_MODE  = 5'h01;
  localparam logic [4:0] LAST_DUMMY = 5'h03;
  localparam logic [4:0] LAST_WRAP  = 5'h01;
  localparam logic [2:0] LAST_BIT1  = 3'h7;
  localparam logic [2:0] LAST_BIT4  = 3'h1;
  localparam logic [1:0] CONT_KEY   = 2'h2; // mode bits 5:4 that keep it on
  localparam logic [23:0] WRAP_MIN  = 24'h000008;
  localparam logic [3:0] OE_QUAD    = 4'hf;
  localparam logic [3:0] OE_SINGLE  = 4'h2;
  localparam int         CLK_NS     = 25;
  localparam int         TMR_W      = 16;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_OPC   = 3'h1,
    ST_ADDR  = 3'h3,
    ST_MODE  = 3'h2,
    ST_DUMMY = 3'h6,
    ST_DATA  = 3'h7,
    ST_WRAP  = 3'h5,
    ST_SKIP  = 3'h4
  } fwr_state_t;

  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic [3:0] io;
  } fwr_pins_t;

  typedef struct packed {
    logic [1:0] len; // section is 8 << len bytes
    logic       dis; // 1: linear reads
  } fwr_wrap_t;

  localparam fwr_pins_t PINS_IDLE  = '{sclk: 1'h0, cs_n: 1'h1, io: 4'h0};
  localparam fwr_wrap_t WRAP_RESET = '{len: 2'h3, dis: 1'h1};
endpackage : fwr_pkg

// ==== fwr_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module fwr_sync #(
  parameter int           W    = 6,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] sync_q
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
endmodule : fwr_sync
`default_nettype wire

// ==== fwr_buf.sv ====
// shifting buffer with valid and ready on both sides, head held in flops
`timescale 1ns/1ps
`default_nettype none
module fwr_buf #(
  parameter int W     = 24,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  logic [W-1:0] mem_q [DEPTH];
  logic [DEPTH-1:0] vld_q;
  wire push = in_valid && in_ready;
  wire pop  = vld_q[0] && out_ready;

  // ready and valid come straight from the occupancy flops
  assign in_ready  = !vld_q[DEPTH-1];
  assign out_valid = vld_q[0];
  assign out_data  = mem_q[0];

  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    wire above_v = (i == DEPTH - 1) ? 1'b0 : vld_q[(i + 1) % DEPTH];
    wire below_v = (i == 0) ? 1'b1 : vld_q[(i + DEPTH - 1) % DEPTH];
    wire [W-1:0] above_d = mem_q[(i + 1) % DEPTH];
    // slot taking the new word: first empty one, one lower on a pop
    wire take = push && (pop ? (vld_q[i] && !above_v)
                             : (!vld_q[i] && below_v));
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        vld_q[i] <= 1'b0;
        mem_q[i] <= '0;
      end else if (take) begin
        vld_q[i] <= 1'b1;
        mem_q[i] <= in_data;
      end else if (pop) begin
        vld_q[i] <= above_v;
        mem_q[i] <= above_d;
      end
    end
  end
endmodule : fwr_buf
`default_nettype wire

// ==== fwr_cmd.sv ====
// serial flash command logic: wrap, software reset, sleep and id reads
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - wrapped quad read cycles inside aligned section
// - set wrap: 77h, 24 dummy, 8 wrap bits
// - keep wrap bits 6..4, ignore the rest
// - wrap bit 4 low enables wrap
// - bits 6..5 pick 8/16/32/64 byte section
// - wrap setting persists until next set wrap or software reset
// - quad enable needed for quad commands
// - wrap disabled after power-on
// - software reset reloads volatile defaults
// - reset ignored in sleep or recovery
// - reset ignored during continuous read mode
// - 66h then 99h; other command disarms
// - sleep only if select rises after 8 bits
// - in sleep only release opcode recognised
// - device powers up awake
// - release then recovery delay before commands
// - abh plus 3 dummy bytes repeats device id
// - release with id uses second recovery delay
// - release/id ignored while busy
// - 90h at address 0: manufacturer then device
// - address 1 starts with device, then alternates
// - opcode and address sampled on rising edges
// - continuous mode skips the opcode byte
module fwr_cmd #(
  parameter int         RES1_NS = 3000, // release_recovery_delay
  parameter int         RES2_NS = 3000, // release_id_recovery_delay
  parameter int         DP_NS   = 3000, // sleep_entry_delay
  parameter logic [7:0] MFR_ID  = fwr_pkg::MFR_ID_DEF,
  parameter logic [7:0] DEV_ID  = fwr_pkg::DEV_ID_DEF
) (
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  input  wire logic          spi_clk,
  input  wire logic          cs_n,
  input  wire logic [3:0]    io_in,
  output logic      [3:0]    io_out,
  output logic      [3:0]    io_oe,
  input  wire logic          quad_enable_bit,
  input  wire logic          busy,
  output logic      [23:0]   read_addr,
  output logic               read_addr_valid,
  input  wire logic          read_addr_ready,
  input  wire logic [7:0]    read_byte,
  output logic               soft_reset,
  output logic               deep_sleep,
  output fwr_pkg::fwr_wrap_t wrap_setting,
  output logic               continuous_mode
);
  localparam int TW = fwr_pkg::TMR_W;
  // least times round up, the longest time rounds down
  localparam int RES1_CYC = (RES1_NS + fwr_pkg::CLK_NS - 1) / fwr_pkg::CLK_NS;
  localparam int RES2_CYC = (RES2_NS + fwr_pkg::CLK_NS - 1) / fwr_pkg::CLK_NS;
  localparam int DP_RAW   = DP_NS / fwr_pkg::CLK_NS;
  localparam int DP_CYC   = (DP_RAW < 1) ? 1 : DP_RAW;
  // window for the sleep entry check, one cycle of slack past the timer
  localparam int DP_WIN   = DP_CYC + 1;

  function automatic logic is_quad(input logic [7:0] op);
    is_quad = (op == fwr_pkg::OP_QREAD) || (op == fwr_pkg::OP_WRAP);
  endfunction : is_quad

  // next byte address, kept inside the aligned section when wrap is on
  function automatic logic [23:0] wrap_next(input logic [23:0] a,
                                            input fwr_pkg::fwr_wrap_t w);
    logic [23:0] m;
    m = (fwr_pkg::WRAP_MIN << w.len) - 24'h1;
    if (w.dis) begin
      wrap_next = a + 24'h1;
    end else begin
      wrap_next = (a & ~m) | ((a + 24'h1) & m);
    end
  endfunction : wrap_next

  fwr_pkg::fwr_pins_t   pin_s;
  fwr_pkg::fwr_state_t  state_q, state_d;
  fwr_pkg::fwr_wrap_t   wrap_q;
  logic                 sclk_q, cs_q;
  logic [4:0]           cnt_q;
  logic [23:0]          sr_q;
  logic [7:0]           op_q, cur_q;
  logic [2:0]           idx_q;
  logic                 ign_q, over_q, arm_q, alt_q, id_seen_q;
  logic                 cont_q, sleep_q, enter_q, srst_q, push_q;
  logic [TW-1:0]        tmr_q;
  logic [23:0]          raddr_q;
  logic [3:0]           io_out_q, io_oe_q;
  logic                 buf_ready;

  fwr_sync #(.W(6), .INIT(fwr_pkg::PINS_IDLE)) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .d       ({spi_clk, cs_n, io_in}),
    .sync_q  (pin_s)
  );

  // pin edges, seen only after the synchroniser
  wire sel     = !pin_s.cs_n;
  wire rise    = pin_s.sclk && !sclk_q;
  wire fall    = !pin_s.sclk && sclk_q;
  wire cs_fall = sel && cs_q;
  wire cs_rise = !sel && !cs_q;
  wire blocked = tmr_q != '0;

  // input shifting: one bit per clock, or four in quad phases
  wire quad = (state_q != fwr_pkg::ST_OPC) && is_quad(op_q);
  wire [23:0] sr_d = quad ? {sr_q[19:0], pin_s.io} : {sr_q[22:0], pin_s.io[0]};
  wire [7:0]  op_new = sr_d[7:0];
  wire [4:0]  last =
      (state_q == fwr_pkg::ST_OPC)   ? fwr_pkg::LAST_OPC :
      (state_q == fwr_pkg::ST_MODE)  ? fwr_pkg::LAST_MODE :
      (state_q == fwr_pkg::ST_DUMMY) ? fwr_pkg::LAST_DUMMY :
      (state_q == fwr_pkg::ST_WRAP)  ? fwr_pkg::LAST_WRAP :
      quad ? fwr_pkg::LAST_ADR4 : fwr_pkg::LAST_ADR1;
  wire ph_end = sel && rise && (cnt_q == last);
  wire op_end = ph_end && (state_q == fwr_pkg::ST_OPC);

  // opcode screening at the eighth bit
  wire op_ign = (sleep_q && op_new != fwr_pkg::OP_RELEASE)
             || (op_new == fwr_pkg::OP_RELEASE && busy)
             || (is_quad(op_new) && !quad_enable_bit);
  wire op_long = is_quad(op_new) || op_new == fwr_pkg::OP_RELEASE
              || op_new == fwr_pkg::OP_MFR_DEV;

  // single-byte commands act only if select rises right after bit 8
  wire done8    = (state_q == fwr_pkg::ST_SKIP) && !over_q && !ign_q;
  wire arm_set  = cs_rise && done8 && op_q == fwr_pkg::OP_RST_EN;
  wire rst_fire = cs_rise && done8 && op_q == fwr_pkg::OP_RST && arm_q
               && !sleep_q && !blocked;
  wire sleep_go = cs_rise && done8 && op_q == fwr_pkg::OP_SLEEP;
  wire release_go = cs_rise && sleep_q && !ign_q
                 && op_q == fwr_pkg::OP_RELEASE
                 && (state_q == fwr_pkg::ST_ADDR
                  || state_q == fwr_pkg::ST_DATA);
  wire wrap_ld  = ph_end && state_q == fwr_pkg::ST_WRAP;

  // output byte selection for the data phase
  wire [7:0] nxt = (op_q == fwr_pkg::OP_QREAD)   ? read_byte :
                   (op_q == fwr_pkg::OP_RELEASE) ? DEV_ID :
                   (alt_q ? DEV_ID : MFR_ID);
  wire [7:0] cur = (idx_q == 3'h0) ? nxt : cur_q;
  wire [2:0] blast = quad ? fwr_pkg::LAST_BIT4 : fwr_pkg::LAST_BIT1;
  wire [3:0] nib = idx_q[0] ? cur[3:0] : cur[7:4];
  wire [3:0] out_d = quad ? nib : {2'h0, cur[fwr_pkg::LAST_BIT1 - idx_q], 1'h0};
  wire shift_out = sel && fall && state_q == fwr_pkg::ST_DATA;
  wire byte_end  = shift_out && idx_q == blast;
  wire adv = shift_out && idx_q == 3'h0 && op_q == fwr_pkg::OP_QREAD;
  wire first_rd = ph_end && state_q == fwr_pkg::ST_DUMMY;

  // command sequencing
  always_comb begin
    state_d = state_q;
    if (!sel) begin
      state_d = fwr_pkg::ST_IDLE;
    end else if (cs_fall) begin
      state_d = blocked ? fwr_pkg::ST_SKIP :
                cont_q ? fwr_pkg::ST_ADDR : fwr_pkg::ST_OPC;
    end else if (ph_end) begin
      unique case (state_q)
        fwr_pkg::ST_OPC: begin
          state_d = (op_long && !op_ign) ? fwr_pkg::ST_ADDR : fwr_pkg::ST_SKIP;
        end
        fwr_pkg::ST_ADDR: begin
          state_d = (op_q == fwr_pkg::OP_QREAD) ? fwr_pkg::ST_MODE :
                    (op_q == fwr_pkg::OP_WRAP)  ? fwr_pkg::ST_WRAP :
                    fwr_pkg::ST_DATA;
        end
        fwr_pkg::ST_MODE:  state_d = fwr_pkg::ST_DUMMY;
        fwr_pkg::ST_DUMMY: state_d = fwr_pkg::ST_DATA;
        fwr_pkg::ST_WRAP:  state_d = fwr_pkg::ST_SKIP;
        fwr_pkg::ST_IDLE, fwr_pkg::ST_DATA, fwr_pkg::ST_SKIP: begin
          state_d = state_q;
        end
      endcase
    end
  end

  // edge history, state and the input shifter
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sclk_q  <= 1'b0;
      cs_q    <= 1'b1;
      state_q <= fwr_pkg::ST_IDLE;
      cnt_q   <= '0;
      sr_q    <= '0;
    end else begin
      sclk_q  <= pin_s.sclk;
      cs_q    <= pin_s.cs_n;
      state_q <= state_d;
      cnt_q   <= (cs_fall || ph_end) ? 5'h00 : (rise ? cnt_q + 5'h01 : cnt_q);
      sr_q    <= (sel && rise) ? sr_d : sr_q;
    end
  end

  // opcode, ignore and overrun flags
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      op_q   <= '0;
      ign_q  <= 1'b0;
      over_q <= 1'b0;
    end else if (cs_fall) begin
      op_q   <= cont_q ? fwr_pkg::OP_QREAD : op_q;
      ign_q  <= blocked;
      over_q <= 1'b0;
    end else if (op_end) begin
      op_q   <= op_new;
      ign_q  <= op_ign;
    end else if (sel && rise && state_q == fwr_pkg::ST_SKIP) begin
      over_q <= 1'b1;
    end
  end

  // reset arming: anything other than 99h after 66h disarms
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      arm_q <= 1'b0;
    end else if (arm_set) begin
      arm_q <= 1'b1;
    end else if (cs_rise || (op_end && op_new != fwr_pkg::OP_RST)) begin
      arm_q <= 1'b0;
    end
  end

  // wrap setting and continuous mode; the reset leaves the latter alone
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wrap_q <= fwr_pkg::WRAP_RESET;
      cont_q <= 1'b0;
      srst_q <= 1'b0;
    end else begin
      srst_q <= rst_fire;
      if (rst_fire) begin
        wrap_q <= fwr_pkg::WRAP_RESET;
      end else if (wrap_ld) begin
        wrap_q <= fwr_pkg::fwr_wrap_t'(sr_d[6:4]);
      end
      if (ph_end && state_q == fwr_pkg::ST_MODE) begin
        cont_q <= sr_d[5:4] == fwr_pkg::CONT_KEY;
      end
    end
  end

  // sleep entry and recovery share one timer; commands are dropped while it runs
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sleep_q <= 1'b0;
      enter_q <= 1'b0;
      tmr_q   <= '0;
    end else if (sleep_go) begin
      enter_q <= 1'b1;
      tmr_q   <= TW'(DP_CYC);
    end else if (release_go) begin
      sleep_q <= 1'b0;
      tmr_q   <= id_seen_q ? TW'(RES2_CYC) : TW'(RES1_CYC);
    end else if (blocked) begin
      tmr_q   <= tmr_q - {{(TW-1){1'b0}}, 1'b1};
      if (enter_q && tmr_q == {{(TW-1){1'b0}}, 1'b1}) begin
        sleep_q <= 1'b1;
        enter_q <= 1'b0;
      end
    end
  end

  // data phase: falling edges shift, oe only while shifting
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      io_out_q  <= '0;
      io_oe_q   <= '0;
      idx_q     <= '0;
      cur_q     <= '0;
      alt_q     <= 1'b0;
      id_seen_q <= 1'b0;
    end else if (state_d != fwr_pkg::ST_DATA) begin
      io_oe_q   <= '0;
      idx_q     <= '0;
      id_seen_q <= cs_fall ? 1'b0 : id_seen_q;
    end else if (ph_end && state_q == fwr_pkg::ST_ADDR) begin
      // data phase is entered here, so bit 0 must be caught on this edge
      alt_q     <= sr_d[0];
    end else if (shift_out) begin
      id_seen_q <= 1'b1;
      io_out_q  <= out_d;
      io_oe_q   <= quad ? fwr_pkg::OE_QUAD : fwr_pkg::OE_SINGLE;
      cur_q     <= cur;
      idx_q     <= byte_end ? 3'h0 : idx_q + 3'h1;
      alt_q     <= byte_end ? !alt_q : alt_q;
    end
  end

  // read addresses toward the array; a full buffer holds the request
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      raddr_q <= '0;
      push_q  <= 1'b0;
    end else begin
      if (ph_end && state_q == fwr_pkg::ST_ADDR) begin
        raddr_q <= sr_d;
      end else if (adv) begin
        raddr_q <= wrap_next(raddr_q, wrap_q);
      end
      push_q <= first_rd || adv || (push_q && !buf_ready);
    end
  end

  fwr_buf #(.W(24), .DEPTH(2)) u_buf (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .in_valid  (push_q),
    .in_ready  (buf_ready),
    .in_data   (raddr_q),
    .out_valid (read_addr_valid),
    .out_ready (read_addr_ready),
    .out_data  (read_addr)
  );

  assign io_out          = io_out_q;
  assign io_oe           = io_oe_q;
  assign soft_reset      = srst_q;
  assign deep_sleep      = sleep_q;
  assign wrap_setting    = wrap_q;
  assign continuous_mode = cont_q;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_reset_seen;
    rst_fire ##1 srst_q;
  endsequence
  sequence s_sleep_cmd;
    sleep_go ##1 enter_q;
  endsequence

  a_oe_in_data: assert property (
    (io_oe_q != '0) |-> (state_q == fwr_pkg::ST_DATA)
  ) else $error("data pins driven outside data phase");
  a_reset_effect: assert property (
    s_reset_seen |-> wrap_q == fwr_pkg::WRAP_RESET && !$past(srst_q)
  ) else $error("software reset did not reload wrap default");
  a_reset_needs_arm: assert property (
    $rose(srst_q) |-> $past(arm_q) && $past(op_q) == fwr_pkg::OP_RST
  ) else $error("reset fired without 66h before 99h");
  a_sleep_ignores_rst: assert property (
    sleep_q |=> !srst_q
  ) else $error("reset accepted in sleep");
  a_sleep_entry: assert property (
    s_sleep_cmd |-> !sleep_q ##[1:DP_WIN] sleep_q
  ) else $error("sleep not entered after sleep command");
  a_sleep_screen: assert property (
    op_end && sleep_q && op_new != fwr_pkg::OP_RELEASE
      |=> state_q == fwr_pkg::ST_SKIP && ign_q
  ) else $error("opcode other than release taken in sleep");
  a_release_busy: assert property (
    op_end && busy && op_new == fwr_pkg::OP_RELEASE
      |=> state_q == fwr_pkg::ST_SKIP
  ) else $error("release taken while busy");
  a_recovery_gap: assert property (
    cs_fall && blocked |=> state_q == fwr_pkg::ST_SKIP
  ) else $error("command taken during recovery");
  a_cont_skips_op: assert property (
    cs_fall && cont_q && !blocked |=> state_q == fwr_pkg::ST_ADDR
  ) else $error("continuous mode did not skip opcode");
  a_wrap_stays: assert property (
    adv && !wrap_q.dis |=> ((raddr_q ^ $past(raddr_q))
      & ~((fwr_pkg::WRAP_MIN << wrap_q.len) - 24'h1)) == 24'h0
  ) else $error("wrapped address left its section");
  a_wrap_holds: assert property (
    $changed(wrap_q) |-> $past(wrap_ld) || $past(rst_fire)
  ) else $error("wrap setting changed without a command");
endmodule : fwr_cmd
`default_nettype wire

// ==== fwr_host.sv ====
// host flash controller model driving select, serial clock and data pins
`timescale 1ns/1ps
`default_nettype none
module fwr_host (
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe,
  output fwr_pkg::fwr_pins_t pins
);
  logic [3:0] h_io  = 4'h0;
  logic [3:0] h_oe  = 4'h0;
  logic       flt   = 1'b0;
  logic       sck   = 1'b0;
  logic       sel_n = 1'b1;
  wire  [3:0] lvl;

  // released lines keep toggling so a stale level never reads as data
  always #25 flt = ~flt;
  assign lvl = (io_oe & io_out) | (~io_oe & h_oe & h_io)
             | (~io_oe & ~h_oe & {4{flt}});
  assign pins = '{sclk: sck, cs_n: sel_n, io: lvl};

  // n clocks of w bits each, driven while low, sampled on the rise
  task automatic sh(input int n, input int w, input logic [3:0] oe,
                    input logic [31:0] v, output logic [31:0] r);
    r = 32'h0;
    for (int k = n - 1; k >= 0; k--) begin
      h_oe = oe;
      h_io = (w == 4) ? v[k*4 +: 4] : {3'h0, v[k]};
      #100 sck = 1'b1;
      r = (w == 4) ? {r[27:0], lvl} : {r[30:0], lvl[1]};
      #100 sck = 1'b0;
    end
  endtask : sh

  task automatic start();
    sel_n = 1'b0;
    #100;
  endtask : start

  // select rises after the last falling edge, then stays high for gap
  task automatic stop(input int gap);
    #100 sel_n = 1'b1;
    h_oe = 4'h0;
    #(gap);
  endtask : stop
endmodule : fwr_host
`default_nettype wire

// ==== fwr_cmd_test.sv ====
// self-checking bench of the wrap, reset, sleep and id command logic
`timescale 1ns/1ps
`default_nettype none
module fwr_cmd_test;
  logic               clk_sys = 1'b0;
  logic               nrst;
  logic               qe;
  logic               busy;
  logic               rdy;
  logic [7:0]         rbyte;
  logic [3:0]         io_out;
  logic [3:0]         io_oe;
  logic [23:0]        raddr;
  logic               rvalid;
  logic               srst;
  logic               sleep;
  logic               cmode;
  fwr_pkg::fwr_wrap_t wset;
  fwr_pkg::fwr_pins_t pins;
  logic [1:0]         wlen    = 2'h3; // bench copy of the wrap setting
  logic               wdis    = 1'b1;
  logic [31:0]        r;
  int                 error_cnt = 0;
  int                 checked   = 0;
  int                 rst_seen  = 0;
  int                 oe_seen   = 0;

  always #12.5 clk_sys = ~clk_sys;

  fwr_host host_u (.io_out(io_out), .io_oe(io_oe), .pins(pins));

  fwr_cmd #(.RES1_NS(300), .RES2_NS(100), .DP_NS(100)) dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .spi_clk(pins.sclk),
    .cs_n(pins.cs_n), .io_in(pins.io), .io_out(io_out), .io_oe(io_oe),
    .quad_enable_bit(qe), .busy(busy), .read_addr(raddr),
    .read_addr_valid(rvalid), .read_addr_ready(rdy), .read_byte(rbyte),
    .soft_reset(srst), .deep_sleep(sleep), .wrap_setting(wset),
    .continuous_mode(cmode));

  function automatic logic [7:0] fbyte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5c;
  endfunction : fbyte

  // array model; stalls last one cycle at most so data is never late
  always @(posedge clk_sys) begin
    if (srst === 1'b1) rst_seen++;
    if (io_oe !== 4'h0) oe_seen++;
    if (!nrst) begin
      rdy   <= #2 1'b1;
      rbyte <= #2 8'h00;
    end else begin
      if (rvalid === 1'b1 && rdy) rbyte <= #2 fbyte(raddr);
      rdy <= #2 !rdy || ($urandom % 4 != 0);
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // opcode-only frame; nb above 8 clocks extra zero bits
  task automatic op(input logic [7:0] o, input int nb);
    host_u.start();
    host_u.sh(nb, 1, 4'hf, {24'h0, o} << (nb - 8), r);
    host_u.stop(400);
  endtask : op

  task automatic idrd(input logic [7:0] o, input logic [23:0] a,
                      input logic [7:0] e0, input logic [7:0] e1,
                      input bit ck);
    host_u.start();
    host_u.sh(8, 1, 4'h1, {24'h0, o}, r);
    host_u.sh(24, 1, 4'h1, {8'h0, a}, r);
    for (int i = 0; i < 4; i++) begin
      host_u.sh(8, 1, 4'h0, 32'h0, r);
      if (ck) chk(r[7:0], i[0] ? e1 : e0);
    end
    host_u.stop(400);
    chk(io_oe, 4'h0);
  endtask : idrd

  task automatic setwrap(input logic [7:0] wb);
    host_u.start();
    host_u.sh(8, 1, 4'h1, {24'h0, fwr_pkg::OP_WRAP}, r);
    host_u.sh(6, 4, 4'hf, $urandom, r);
    host_u.sh(2, 4, 4'hf, {24'h0, wb}, r);
    host_u.stop(400);
    if (qe) {wlen, wdis} = wb[6:4];
    chk(wset, {wlen, wdis});
  endtask : setwrap

  task automatic qrd(input bit skip, input logic [23:0] a,
                     input logic [7:0] m, input int n);
    logic [23:0] l;
    logic [23:0] ea;
    l = 24'(8 << wlen) - 24'h1;
    host_u.start();
    if (!skip)
      host_u.sh(8, 1, 4'h1, {24'h0, fwr_pkg::OP_QREAD}, r);
    host_u.sh(6, 4, 4'hf, {8'h0, a}, r);
    host_u.sh(2, 4, 4'hf, {24'h0, m}, r);
    host_u.sh(4, 4, 4'h0, 32'h0, r);
    for (int i = 0; i < n; i++) begin
      ea = 24'(a + i);
      if (!wdis) ea = (a & ~l) | (ea & l);
      host_u.sh(2, 4, 4'h0, 32'h0, r);
      chk(r[7:0], fbyte(ea));
    end
    host_u.stop(400);
    chk(cmode, m[5:4] == 2'b10);
  endtask : qrd

  // hang guard, far beyond the expected run length
  initial begin
    #1000000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    nrst = 1'b0;
    qe   = 1'b1;
    busy = 1'b0;
    void'($urandom(44391));
    repeat (16) @(posedge clk_sys);
    #2 nrst = 1'b1;
    repeat (4) @(posedge clk_sys);
    #2;
    chk(wset, 3'h7);
    chk(sleep, 1'b0);
    idrd(fwr_pkg::OP_MFR_DEV, 24'h0, fwr_pkg::MFR_ID_DEF,
         fwr_pkg::DEV_ID_DEF, 1'b1);
    idrd(fwr_pkg::OP_MFR_DEV, 24'h1, fwr_pkg::DEV_ID_DEF,
         fwr_pkg::MFR_ID_DEF, 1'b1);
    idrd(fwr_pkg::OP_RELEASE, 24'($urandom), fwr_pkg::DEV_ID_DEF,
         fwr_pkg::DEV_ID_DEF, 1'b1);
    // every section length, stray values in the unused wrap bits
    for (int k = 0; k < 4; k++) begin
      setwrap({1'($urandom), 2'(k), 1'b0, 4'($urandom)});
      qrd(1'b0, 24'($urandom), 8'hff, (8 << k) + 3);
    end
    setwrap(8'h90);
    qrd(1'b0, 24'h0000fe, 8'h00, 6);
    qe = 1'b0;
    setwrap(8'h00);
    qe = 1'b1;
    qrd(1'b0, 24'h000123, 8'hff, 3);
    setwrap(8'h20);
    op(fwr_pkg::OP_RST_EN, 8);
    op(fwr_pkg::OP_MFR_DEV, 8);
    op(fwr_pkg::OP_RST, 8);
    chk(rst_seen, 0);
    op(fwr_pkg::OP_RST_EN, 8);
    op(fwr_pkg::OP_RST, 8);
    {wlen, wdis} = 3'h7;
    chk(rst_seen, 1);
    chk(wset, 3'h7);
    op(fwr_pkg::OP_SLEEP, 9);
    chk(sleep, 1'b0);
    op(fwr_pkg::OP_SLEEP, 8);
    chk(sleep, 1'b1);
    oe_seen = 0;
    idrd(fwr_pkg::OP_MFR_DEV, 24'h0, 8'h00, 8'h00, 1'b0);
    chk(oe_seen, 0);
    op(fwr_pkg::OP_RST_EN, 8);
    op(fwr_pkg::OP_RST, 8);
    chk(rst_seen, 1);
    busy = 1'b1;
    op(fwr_pkg::OP_RELEASE, 8);
    chk(sleep, 1'b1);
    busy = 1'b0;
    // release, then a sleep command inside the recovery time is dropped
    host_u.start();
    host_u.sh(8, 1, 4'hf, {24'h0, fwr_pkg::OP_RELEASE}, r);
    host_u.stop(100);
    op(fwr_pkg::OP_SLEEP, 8);
    chk(sleep, 1'b0);
    op(fwr_pkg::OP_RST_EN, 8);
    op(fwr_pkg::OP_RST, 8);
    chk(rst_seen, 2);
    op(fwr_pkg::OP_SLEEP, 8);
    idrd(fwr_pkg::OP_RELEASE, 24'h0, fwr_pkg::DEV_ID_DEF,
         fwr_pkg::DEV_ID_DEF, 1'b1);
    chk(sleep, 1'b0);
    // a frame in continuous mode is a read, so the reset pair is lost
    qrd(1'b0, 24'h000040, 8'h20, 2);
    op(fwr_pkg::OP_RST_EN, 8);
    op(fwr_pkg::OP_RST, 8);
    chk(rst_seen, 2);
    chk(cmode, 1'b0);
    qrd(1'b0, 24'h000233, 8'h20, 2);
    qrd(1'b1, 24'h000087, 8'hff, 3);
    give_verdict();
  end
endmodule : fwr_cmd_test
`default_nettype wire
